// file: verilog/agm_pkg.sv
// Constants, types and register map of the effective-address generator.
// Assumes an APB master with 32-bit data and one aligned word per register.
package agm_pkg;

   // ---------------------------------------------
   // Register map (byte offsets)
   // ---------------------------------------------
   localparam logic [7:0]  OFF_XSTART = 8'h00;
   localparam logic [7:0]  OFF_XEND   = 8'h04;
   localparam logic [7:0]  OFF_YSTART = 8'h08;
   localparam logic [7:0]  OFF_YEND   = 8'h0c;
   localparam logic [7:0]  OFF_CTRL   = 8'h10;
   localparam logic [7:0]  OFF_LASTEA = 8'h14;
   localparam logic [7:0]  OFF_STAT   = 8'h18;

   // ---------------------------------------------
   // Reset values and fields
   // ---------------------------------------------
   localparam logic [15:0] RST_ADDR   = 16'h0000;
   localparam logic [15:0] RST_CTRL   = 16'h00ff;
   localparam int          CTRL_XSEL  = 0;
   localparam int          CTRL_YSEL  = 4;
   localparam int          CTRL_YEN   = 14;
   localparam int          CTRL_XEN   = 15;
   localparam logic [3:0]  SEL_OFF    = 4'hf;
   localparam int          ST_ILL     = 0;
   localparam int          ST_WRAP    = 1;
   localparam int          ST_YSP     = 2;

   // ---------------------------------------------
   // Working register numbers
   // ---------------------------------------------
   localparam logic [3:0]  WORKING_REG_ZERO = 4'h0;
   localparam logic [3:0]  X_PREFETCH_PTR_A = 4'h8;
   localparam logic [3:0]  X_PREFETCH_PTR_B = 4'h9;
   localparam logic [3:0]  Y_PREFETCH_PTR_A = 4'ha;
   localparam logic [3:0]  Y_PREFETCH_PTR_B = 4'hb;

   // ---------------------------------------------
   // Types
   // ---------------------------------------------
   typedef enum logic [11:0] {
      MD_FILE   = 12'h001,
      MD_DIRECT = 12'h002,
      MD_IND    = 12'h004,
      MD_POST   = 12'h008,
      MD_PRE    = 12'h010,
      MD_INDEX  = 12'h020,
      MD_LITOFF = 12'h040,
      MD_LIT5   = 12'h080,
      MD_LIT8   = 12'h100,
      MD_LIT16  = 12'h200,
      MD_BRANCH = 12'h400,
      MD_INTERRUPT_DISABLE_INSTRUCTION   = 12'h800
   } agm_mode_t;

   typedef enum logic [4:0] {
      CL_FILE = 5'h01,
      CL_MUL  = 5'h02,
      CL_MCU  = 5'h04,
      CL_MOVE = 5'h08,
      CL_DSP  = 5'h10
   } agm_class_t;

   typedef enum logic [4:0] {
      DS_NONE  = 5'h01,
      DS_FILE  = 5'h02,
      DS_WZERO = 5'h04,
      DS_PAIR  = 5'h08,
      DS_IMPLIED_WORKING_REG  = 5'h10
   } agm_dest_t;

   typedef struct packed {
      agm_mode_t   mode;
      agm_class_t  cls;
      logic        y_space;
      logic [3:0]  ptr;
      logic [3:0]  offs;
      logic [3:0]  base;
      logic [15:0] lit;
      logic [15:0] modv;
      logic        to_w;
      logic [12:0] faddr;
   } agm_req_t;

   typedef struct packed {
      logic [15:0] ea;
      logic [15:0] opa;
      logic [15:0] opb;
      agm_dest_t   dest;
      logic [3:0]  dest_idx;
      logic        y_space;
      logic        illegal;
      logic        wrap;
   } agm_ans_t;

endpackage

// file: verilog/agm_top.sv
// Effective-address generator with circular buffer correction.
// Assumes the decoder drives REQ on the core clock; working register
// writes from the datapath arrive on the WR_* port on the same clock.
`timescale 1ns/1ns

// How it works
// - File operand: 13-bit field, near space only
// - File ops: reg zero operand, dest file/reg
// - Multiply writes a register pair instead, or the working register when to_w
// - First source register direct; second reg/mem/lit5
// - Plain indirect: pointer itself is address
// - Post-modify: old pointer used, then stepped
// - Pre-modify: step pointer, then use it
// - Indexed and literal offset keep pointer
// - Move/accumulator add indexed, literal offset, lit8/16
// - Move source/destination share one offset field
// - DSP prefetch: first two X, last two Y
// - DSP modes: indirect, post 2/4/6, indexed
// - Branch signed 16-bit, disable count 14-bit
// - One circular buffer per X and Y
// - Both buffer boundaries checked, whatever the direction
// - 16-bit start/end, length from difference
// - Y modulo addresses keep bit zero clear
// - X modulo on when select not 15, enabled
// - Y modulo on when select not 15, enabled
// - Overshoot past boundary still detected, corrected
// - Corrected address written back only pre/post
module agm_top (
   // Clock and reset
   input  wire logic             CLK,
   input  wire logic             RESET_N,
   // APB slave
   input  wire logic             PSEL,
   input  wire logic             PENABLE,
   input  wire logic             PWRITE,
   input  wire logic [7:0]       PADDR,
   input  wire logic [31:0]      PWDATA,
   input  wire logic [3:0]       PSTRB,
   output logic      [31:0]      PRDATA,
   output logic                  PREADY,
   output logic                  PSLVERR,
   // Decoder request
   input  wire logic             REQ_VALID,
   input  agm_pkg::agm_req_t     REQ,
   // Datapath working register write
   input  wire logic             WR_EN,
   input  wire logic [3:0]       WR_IDX,
   input  wire logic [15:0]      WR_DATA,
   // Address answer
   output logic                  ANS_VALID,
   output agm_pkg::agm_ans_t     ANS
);

   // ---------------------------------------------
   // Register file
   // ---------------------------------------------
   logic [15:0] xstart_q;
   logic [15:0] xend_q;
   logic [15:0] ystart_q;
   logic [15:0] yend_q;
   logic [15:0] ctrl_q;
   logic [15:0] implied_working_reg_q [16];
   logic        pready_q;
   logic [31:0] prdata_q;
   logic        pslverr_q;
   logic        ans_valid_q;
   agm_pkg::agm_ans_t ans_q;

   logic        setup_acc;
   logic        done_acc;
   logic        mapped;
   logic [15:0] wmask;
   logic [15:0] rd_word;

   assign setup_acc = PSEL && PENABLE && !pready_q;
   assign done_acc  = PSEL && PENABLE && pready_q;
   assign wmask     = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};

   always_comb begin
      mapped  = 1'b1;
      rd_word = 16'h0000;
      unique case (PADDR)
         agm_pkg::OFF_XSTART: rd_word = xstart_q;
         agm_pkg::OFF_XEND:   rd_word = xend_q;
         agm_pkg::OFF_YSTART: rd_word = ystart_q;
         agm_pkg::OFF_YEND:   rd_word = yend_q;
         agm_pkg::OFF_CTRL:   rd_word = ctrl_q;
         agm_pkg::OFF_LASTEA: rd_word = ans_q.ea;
         agm_pkg::OFF_STAT: begin
            rd_word[agm_pkg::ST_ILL]  = ans_q.illegal;
            rd_word[agm_pkg::ST_WRAP] = ans_q.wrap;
            rd_word[agm_pkg::ST_YSP]  = ans_q.y_space;
         end
         default: mapped = 1'b0;
      endcase
   end

   // Two-cycle slave: ready rises one cycle into the access phase
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= setup_acc;
         if (setup_acc) begin
            prdata_q  <= PWRITE ? 32'h0000_0000 : {16'h0000, rd_word};
            pslverr_q <= !mapped;
         end else if (done_acc) begin
            pslverr_q <= 1'b0;
         end
      end
   end

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] mask);
      merge = (old & ~mask) | (PWDATA[15:0] & mask);
   endfunction

   // Start/end and control registers are the only buffer state
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         xstart_q <= agm_pkg::RST_ADDR;
         xend_q   <= agm_pkg::RST_ADDR;
         ystart_q <= agm_pkg::RST_ADDR;
         yend_q   <= agm_pkg::RST_ADDR;
         ctrl_q   <= agm_pkg::RST_CTRL;
      end else if (done_acc && PWRITE) begin
         unique case (PADDR)
            agm_pkg::OFF_XSTART: xstart_q <= merge(xstart_q, wmask);
            agm_pkg::OFF_XEND:   xend_q   <= merge(xend_q, wmask);
            agm_pkg::OFF_YSTART: ystart_q <= merge(ystart_q, wmask);
            agm_pkg::OFF_YEND:   yend_q   <= merge(yend_q, wmask);
            agm_pkg::OFF_CTRL:   ctrl_q   <= merge(ctrl_q, wmask);
            default: ;
         endcase
      end
   end

   // ---------------------------------------------
   // Operand fetch and address arithmetic
   // ---------------------------------------------
   logic [15:0] ptr_val;
   logic [15:0] offs_val;
   logic [15:0] base_val;
   logic [15:0] raw;
   logic [15:0] corr;
   logic [15:0] lo;
   logic [15:0] hi;
   logic [15:0] len;
   logic        ysp;
   logic        x_on;
   logic        y_on;
   logic        mod_on;
   logic        over;
   logic        under;
   logic        legal;
   logic        step;
   logic        dsp_ptr;
   logic        mag_ok;
   logic [15:0] mag;
   agm_pkg::agm_ans_t nxt;

   assign ptr_val  = implied_working_reg_q[REQ.ptr];
   // One offset field serves either operand of a move
   assign offs_val = implied_working_reg_q[REQ.offs];
   assign base_val = implied_working_reg_q[REQ.base];

   // Prefetch pointers pick the space by number
   assign dsp_ptr = REQ.ptr[3:2] == agm_pkg::X_PREFETCH_PTR_A[3:2];
   assign ysp = (REQ.cls == agm_pkg::CL_DSP) ?
                REQ.ptr[1] : REQ.y_space;

   // Circular buffer enables
   assign x_on = !ysp && ctrl_q[agm_pkg::CTRL_XEN] &&
                 ctrl_q[agm_pkg::CTRL_XSEL +: 4] != agm_pkg::SEL_OFF &&
                 ctrl_q[agm_pkg::CTRL_XSEL +: 4] == REQ.ptr;
   assign y_on = ysp && ctrl_q[agm_pkg::CTRL_YEN] &&
                 ctrl_q[agm_pkg::CTRL_YSEL +: 4] != agm_pkg::SEL_OFF &&
                 ctrl_q[agm_pkg::CTRL_YSEL +: 4] == REQ.ptr;

   assign lo  = ysp ? ystart_q : xstart_q;
   assign hi  = ysp ? yend_q : xend_q;
   // Length is implied by the address pair
   assign len = 16'(hi - lo + 16'h0001);

   assign mag = REQ.modv[15] ? 16'(~REQ.modv + 16'h0001) : REQ.modv;
   assign mag_ok = mag == 16'h0002 || mag == 16'h0004 ||
                   mag == 16'h0006;

   always_comb begin
      raw = ptr_val;
      unique case (REQ.mode)
         agm_pkg::MD_POST,
         agm_pkg::MD_PRE:    raw = 16'(ptr_val + REQ.modv);
         agm_pkg::MD_INDEX:  raw = 16'(ptr_val + offs_val);
         agm_pkg::MD_LITOFF: raw = 16'(ptr_val + REQ.lit);
         default:            raw = ptr_val;
      endcase
   end

   assign step   = REQ.mode == agm_pkg::MD_POST ||
                   REQ.mode == agm_pkg::MD_PRE ||
                   REQ.mode == agm_pkg::MD_INDEX ||
                   REQ.mode == agm_pkg::MD_LITOFF;
   assign mod_on = (x_on || y_on) && step;
   // Crossings by more than one step still count
   assign over   = mod_on && raw > hi;
   assign under  = mod_on && raw < lo;

   always_comb begin
      corr = raw;
      // Wrap by one buffer length
      if (over) begin
         corr = 16'(raw - len);
      end else if (under) begin
         corr = 16'(raw + len);
      end
      // Word data in Y circular buffers
      if (y_on) begin
         corr[0] = 1'b0;
      end
   end

   // ---------------------------------------------
   // Mode legality per instruction class
   // ---------------------------------------------
   always_comb begin
      legal = 1'b0;
      unique case (REQ.cls)
         agm_pkg::CL_FILE,
         agm_pkg::CL_MUL: legal = REQ.mode == agm_pkg::MD_FILE;
         // Basic set plus 5-bit literal, branch and disable
         agm_pkg::CL_MCU: legal = REQ.mode == agm_pkg::MD_DIRECT ||
                                  REQ.mode == agm_pkg::MD_IND ||
                                  REQ.mode == agm_pkg::MD_POST ||
                                  REQ.mode == agm_pkg::MD_PRE ||
                                  REQ.mode == agm_pkg::MD_LIT5 ||
                                  REQ.mode == agm_pkg::MD_BRANCH ||
                                  REQ.mode == agm_pkg::MD_INTERRUPT_DISABLE_INSTRUCTION;
         // Wider set for moves
         agm_pkg::CL_MOVE: legal = REQ.mode != agm_pkg::MD_LIT5 &&
                                   REQ.mode != agm_pkg::MD_BRANCH &&
                                   REQ.mode != agm_pkg::MD_INTERRUPT_DISABLE_INSTRUCTION;
         // Reduced set on prefetch pointers
         agm_pkg::CL_DSP: legal = dsp_ptr && (
                  REQ.mode == agm_pkg::MD_IND ||
                  (REQ.mode == agm_pkg::MD_POST && mag_ok) ||
                  (REQ.mode == agm_pkg::MD_INDEX && REQ.ptr[0]));
         default: legal = 1'b0;
      endcase
   end

   // ---------------------------------------------
   // Answer assembly
   // ---------------------------------------------
   always_comb begin
      nxt          = '0;
      nxt.opa      = base_val;
      nxt.dest     = agm_pkg::DS_NONE;
      nxt.dest_idx = REQ.base;
      nxt.y_space  = ysp;
      nxt.illegal  = !legal;
      nxt.wrap     = over || under;
      unique case (REQ.mode)
         // Near space only
         agm_pkg::MD_FILE:   nxt.ea  = {3'b000, REQ.faddr};
         // Register direct second source
         agm_pkg::MD_DIRECT: nxt.opb = ptr_val;
         agm_pkg::MD_IND:    nxt.ea  = ptr_val;
         agm_pkg::MD_POST:   nxt.ea  = ptr_val;
         agm_pkg::MD_PRE:    nxt.ea  = corr;
         agm_pkg::MD_INDEX,
         agm_pkg::MD_LITOFF: nxt.ea  = corr;
         agm_pkg::MD_LIT5:   nxt.opb = {11'h000, REQ.lit[4:0]};
         agm_pkg::MD_LIT8:   nxt.opb = {8'h00, REQ.lit[7:0]};
         agm_pkg::MD_LIT16:  nxt.opb = REQ.lit;
         agm_pkg::MD_BRANCH: nxt.opb = REQ.lit;
         agm_pkg::MD_INTERRUPT_DISABLE_INSTRUCTION:   nxt.opb = {2'b00, REQ.lit[13:0]};
         default:            nxt.ea  = ptr_val;
      endcase
      unique case (REQ.cls)
         agm_pkg::CL_FILE: begin
            // Implied working operand and its destination
            nxt.opa      = implied_working_reg_q[agm_pkg::WORKING_REG_ZERO];
            nxt.dest     = REQ.to_w ? agm_pkg::DS_WZERO :
                                      agm_pkg::DS_FILE;
            nxt.dest_idx = agm_pkg::WORKING_REG_ZERO;
         end
         agm_pkg::CL_MUL: begin
            // Product goes to a register pair, or to the working register when to_w
            nxt.opa  = implied_working_reg_q[agm_pkg::WORKING_REG_ZERO];
            nxt.dest = REQ.to_w ? agm_pkg::DS_IMPLIED_WORKING_REG :
                                  agm_pkg::DS_PAIR;
         end
         default: ;
      endcase
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ans_valid_q <= 1'b0;
         ans_q       <= '0;
      end else begin
         ans_valid_q <= REQ_VALID;
         if (REQ_VALID) begin
            ans_q <= nxt;
         end
      end
   end

   // ---------------------------------------------
   // Working registers and pointer write-back
   // ---------------------------------------------
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         for (int i = 0; i < 16; i++) begin
            implied_working_reg_q[i] <= 16'h0000;
         end
      end else begin
         if (WR_EN) begin
            implied_working_reg_q[WR_IDX] <= WR_DATA;
         end
         // Only pre/post modes update the pointer
         if (REQ_VALID && legal && (REQ.mode == agm_pkg::MD_POST ||
                                    REQ.mode == agm_pkg::MD_PRE)) begin
            implied_working_reg_q[REQ.ptr] <= corr;
         end
      end
   end

   assign PRDATA    = prdata_q;
   assign PREADY    = pready_q;
   assign PSLVERR   = pslverr_q;
   assign ANS_VALID = ans_valid_q;
   assign ANS       = ans_q;

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);

   sequence s_req(agm_pkg::agm_mode_t m);
      REQ_VALID && REQ.mode == m;
   endsequence

   sequence s_quiet;
      !WR_EN;
   endsequence

   property p_file;
      s_req(agm_pkg::MD_FILE) |=> ANS.ea == {3'b000, $past(REQ.faddr)};
   endproperty
   a_file: assert property (p_file)
      else $error("file address not near");

   property p_ind;
      s_req(agm_pkg::MD_IND) |=> ANS.ea == $past(ptr_val);
   endproperty
   a_ind: assert property (p_ind)
      else $error("indirect address wrong");

   property p_post;
      s_req(agm_pkg::MD_POST) ##0 s_quiet ##0 (legal && !mod_on) |=>
         ANS.ea == $past(ptr_val) &&
         implied_working_reg_q[$past(REQ.ptr)] == 16'($past(ptr_val) + $past(REQ.modv));
   endproperty
   a_post: assert property (p_post)
      else $error("post-modify wrong");

   property p_pre;
      s_req(agm_pkg::MD_PRE) ##0 s_quiet ##0 legal |=>
         ANS.ea == implied_working_reg_q[$past(REQ.ptr)];
   endproperty
   a_pre: assert property (p_pre)
      else $error("pre-modify address not new pointer");

   property p_keep;
      (s_req(agm_pkg::MD_INDEX) or s_req(agm_pkg::MD_LITOFF)) ##0 s_quiet
         |=> implied_working_reg_q[$past(REQ.ptr)] == $past(ptr_val);
   endproperty
   a_keep: assert property (p_keep)
      else $error("offset mode changed pointer");

   property p_mcu_lit;
      s_req(agm_pkg::MD_LITOFF) ##0 REQ.cls == agm_pkg::CL_MCU
         |=> ANS.illegal;
   endproperty
   a_mcu_lit: assert property (p_mcu_lit)
      else $error("mcu literal offset accepted");

   property p_dsp_idx;
      s_req(agm_pkg::MD_INDEX) ##0 REQ.cls == agm_pkg::CL_DSP ##0
         !REQ.ptr[0] |=> ANS.illegal;
   endproperty
   a_dsp_idx: assert property (p_dsp_idx)
      else $error("indexed dsp on first pointer");

   property p_x_off;
      REQ_VALID && !ysp &&
         ctrl_q[agm_pkg::CTRL_XSEL +: 4] == agm_pkg::SEL_OFF |=> !ANS.wrap;
   endproperty
   a_x_off: assert property (p_x_off)
      else $error("x wrap while disabled");

   property p_y_word;
      REQ_VALID && y_on ##0 (REQ.mode == agm_pkg::MD_PRE ||
         REQ.mode == agm_pkg::MD_INDEX) |=> !ANS.ea[0];
   endproperty
   a_y_word: assert property (p_y_word)
      else $error("y modulo address odd");

   property p_wrap;
      REQ_VALID && mod_on && raw > hi &&
         REQ.mode == agm_pkg::MD_INDEX |=>
         ANS.wrap && ANS.ea == (16'($past(raw) - $past(len)) &
                                ~{15'h0000, $past(y_on)});
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("overshoot not wrapped");

   property p_apb;
      PSEL && PENABLE && PREADY |=> !PREADY;
   endproperty
   a_apb: assert property (p_apb)
      else $error("ready held past transfer");

endmodule

// file: verification/agm_dec_model.sv
// Decoder-side partner: issues one address request and captures the answer.
// Assumes the answer pulse follows the request edge by exactly one clock.
`timescale 1ns/1ns
module agm_dec_model (
   // Clock
   input  wire logic         CLK,
   // Request side
   output logic              REQ_VALID,
   output agm_pkg::agm_req_t REQ,
   // Answer side
   input  wire logic         ANS_VALID,
   input  agm_pkg::agm_ans_t ANS
);
   agm_pkg::agm_ans_t got;
   logic              ok;

   initial begin
      REQ_VALID = 1'b0;
      REQ       = '0;
   end

   // Released request shows the inverse, never the stale value
   task automatic issue(input agm_pkg::agm_req_t q);
      @(posedge CLK);
      REQ_VALID <= 1'b1;
      REQ       <= q;
      @(posedge CLK);
      REQ_VALID <= 1'b0;
      REQ       <= agm_pkg::agm_req_t'(~q);
      @(negedge CLK);
      ok  = ANS_VALID;
      got = ANS;
   endtask
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the effective-address generator.
// Assumes the design package and the decoder model are compiled first.
`timescale 1ns/1ns
module tb_top;
   // ---------------------------------------------
   // Signals
   // ---------------------------------------------
   logic              CLK        = 1'b0;
   logic              RESET_N    = 1'b0;
   logic              PSEL       = 1'b0;
   logic              PENABLE    = 1'b0;
   logic              PWRITE     = 1'b0;
   logic [7:0]        PADDR      = 8'h00;
   logic [31:0]       PWDATA     = 32'h0;
   logic [3:0]        PSTRB      = 4'hf;
   logic              WR_EN      = 1'b0;
   logic [3:0]        WR_IDX     = 4'h0;
   logic [15:0]       WR_DATA    = 16'h0;
   logic [31:0]       PRDATA;
   logic              PREADY;
   logic              PSLVERR;
   logic              REQ_VALID;
   logic              ANS_VALID;
   agm_pkg::agm_req_t REQ;
   agm_pkg::agm_ans_t ANS;
   agm_pkg::agm_req_t r;
   logic [31:0]       seed       = 32'h9345;
   logic [31:0]       rd;
   logic [31:0]       rn;
   logic              err;
   logic [15:0]       v;
   logic [3:0]        p;
   int                mismatches = 0;
   int                cmp_count  = 0;
   localparam logic [15:0] XS     = 16'h1000;
   localparam logic [15:0] XE     = 16'h100f;
   localparam logic [15:0] CT [4] = '{16'h00ff, 16'h80ff, 16'h00f1, 16'h40f1};
   localparam logic [11:0] LM [6] = '{12'h100, 12'h100, 12'h020, 12'h200, 12'h080, 12'h040};
   localparam logic [4:0]  LC [6] = '{5'h04, 5'h08, 5'h04, 5'h08, 5'h04, 5'h04};
   localparam logic        LI [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
   localparam logic [3:0]  DP [6] = '{4'h8, 4'h3, 4'h9, 4'h8, 4'ha, 4'ha};
   localparam logic [11:0] DM [6] = '{12'h004, 12'h004, 12'h020, 12'h020, 12'h008, 12'h008};
   localparam logic [15:0] DV [6] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h6, 16'h8};
   localparam logic        DI [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

   always #2 CLK = ~CLK;

   agm_top u_dut (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .REQ_VALID(REQ_VALID), .REQ(REQ), .WR_EN(WR_EN),
      .WR_IDX(WR_IDX), .WR_DATA(WR_DATA), .ANS_VALID(ANS_VALID), .ANS(ANS));
   agm_dec_model u_dec (.CLK(CLK), .REQ_VALID(REQ_VALID), .REQ(REQ),
      .ANS_VALID(ANS_VALID), .ANS(ANS));

   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task automatic test_done();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [15:0] wrapx(input logic [15:0] a, s, e);
      logic [15:0] len;
      len = e - s + 16'h1;
      if (a > e) return a - len;
      if (a < s) return a + len;
      return a;
   endfunction

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge CLK);
      PSEL    <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE  <= w;
      PADDR   <= a;
      PWDATA  <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      if (PREADY !== 1'b1) begin
         mismatches++;
         test_done();
      end
      rd = PRDATA;
      err = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
      PWDATA  <= ~d;
   endtask

   task automatic implied_working_reg(input logic [3:0] i, input logic [15:0] d);
      @(posedge CLK);
      WR_EN   <= 1'b1;
      WR_IDX  <= i;
      WR_DATA <= d;
      @(posedge CLK);
      WR_EN   <= 1'b0;
   endtask

   task automatic go(input agm_pkg::agm_mode_t m, input agm_pkg::agm_class_t c,
                     input logic [3:0] n, input logic [15:0] l, input logic [15:0] s);
      r.mode = m;
      r.cls  = c;
      r.ptr  = n;
      r.lit  = l;
      r.modv = s;
      u_dec.issue(r);
      chk("answer pulse", 32'h1, {31'h0, u_dec.ok});
   endtask

   task automatic ptr_is(input logic [3:0] n, input logic [15:0] e);
      go(agm_pkg::MD_IND, agm_pkg::CL_MCU, n, 16'h0, 16'h0);
      chk("pointer", {16'h0, e}, u_dec.got.ea);
   endtask

   // ---------------------------------------------
   // Sequence
   // ---------------------------------------------
   initial begin
      r = '0;
      repeat (10) @(posedge CLK);
      RESET_N <= 1'b1;
      apb(1'b0, agm_pkg::OFF_CTRL, 32'h0);
      chk("control reset", 32'h00ff, rd);
      apb(1'b0, 8'h1c, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      apb(1'b1, agm_pkg::OFF_XSTART, 32'h1000);
      apb(1'b1, agm_pkg::OFF_XEND, 32'hffff100f);
      apb(1'b1, agm_pkg::OFF_YSTART, 32'h2000);
      apb(1'b1, agm_pkg::OFF_YEND, 32'h200f);
      apb(1'b0, agm_pkg::OFF_XEND, 32'h0);
      chk("x end", 32'h100f, rd);
      implied_working_reg(4'h1, 16'h1000);
      implied_working_reg(4'h2, 16'h0014);
      go(agm_pkg::MD_IND, agm_pkg::CL_MCU, 4'h1, 16'h0, 16'h0);
      chk("indirect", 32'h1000, u_dec.got.ea);
      go(agm_pkg::MD_POST, agm_pkg::CL_MCU, 4'h1, 16'h0, 16'h2);
      chk("post ea", 32'h1000, u_dec.got.ea);
      ptr_is(4'h1, 16'h1002);
      go(agm_pkg::MD_PRE, agm_pkg::CL_MCU, 4'h1, 16'h0, 16'hfffc);
      chk("pre ea", 32'h0ffe, u_dec.got.ea);
      r.offs = 4'h2;
      foreach (CT[i]) begin
         apb(1'b1, agm_pkg::OFF_CTRL, {16'h0, CT[i]});
         go(agm_pkg::MD_INDEX, agm_pkg::CL_MOVE, 4'h1, 16'h0, 16'h0);
         chk("indexed", 32'h1012, u_dec.got.ea);
      end
      go(agm_pkg::MD_LITOFF, agm_pkg::CL_MOVE, 4'h1, 16'h0030, 16'h0);
      chk("literal offset", 32'h102e, u_dec.got.ea);
      ptr_is(4'h1, 16'h0ffe);
      apb(1'b1, agm_pkg::OFF_CTRL, 32'h0000c031);
      implied_working_reg(4'h1, 16'h100c);
      go(agm_pkg::MD_POST, agm_pkg::CL_MCU, 4'h1, 16'h0, 16'h6);
      chk("modulo post ea", 32'h100c, u_dec.got.ea);
      chk("wrap flag", 32'h1, {31'h0, u_dec.got.wrap});
      ptr_is(4'h1, wrapx(16'h1012, XS, XE));
      go(agm_pkg::MD_PRE, agm_pkg::CL_MCU, 4'h1, 16'h0, 16'hfffc);
      chk("modulo pre", {16'h0, wrapx(16'h0ffe, XS, XE)}, u_dec.got.ea);
      implied_working_reg(4'h2, 16'h0008);
      go(agm_pkg::MD_INDEX, agm_pkg::CL_MOVE, 4'h1, 16'h0, 16'h0);
      chk("modulo index", {16'h0, wrapx(16'h1016, XS, XE)}, u_dec.got.ea);
      apb(1'b0, agm_pkg::OFF_STAT, 32'h0);
      chk("status", 32'h1 << agm_pkg::ST_WRAP, rd);
      apb(1'b0, agm_pkg::OFF_LASTEA, 32'h0);
      chk("last ea", {16'h0, wrapx(16'h1016, XS, XE)}, rd);
      ptr_is(4'h1, 16'h100e);
      r.y_space = 1'b1;
      implied_working_reg(4'h3, 16'h200e);
      go(agm_pkg::MD_POST, agm_pkg::CL_MCU, 4'h3, 16'h0, 16'h4);
      ptr_is(4'h3, wrapx(16'h2012, 16'h2000, 16'h200f));
      go(agm_pkg::MD_PRE, agm_pkg::CL_MCU, 4'h3, 16'h0, 16'h0001);
      chk("y word ea", 32'h2002, u_dec.got.ea);
      go(agm_pkg::MD_POST, agm_pkg::CL_MCU, 4'h1, 16'h0, 16'h4);
      ptr_is(4'h1, 16'h1012);
      r.y_space = 1'b0;
      implied_working_reg(4'h0, 16'h5a5a);
      r.faddr = 13'h1abc;
      for (int t = 0; t < 2; t++) begin
         r.to_w = t[0];
         go(agm_pkg::MD_FILE, agm_pkg::CL_FILE, 4'h0, 16'h0, 16'h0);
         chk("file ea", 32'h1abc, u_dec.got.ea);
         chk("file opa", 32'h5a5a, u_dec.got.opa);
         chk("file dest", t ? agm_pkg::DS_WZERO : agm_pkg::DS_FILE, u_dec.got.dest);
      end
      r.to_w = 1'b0;
      r.base = 4'h6;
      go(agm_pkg::MD_FILE, agm_pkg::CL_MUL, 4'h0, 16'h0, 16'h0);
      chk("mul dest", agm_pkg::DS_PAIR, u_dec.got.dest);
      chk("mul index", 32'h6, u_dec.got.dest_idx);
      foreach (LM[i]) begin
         go(agm_pkg::agm_mode_t'(LM[i]), agm_pkg::agm_class_t'(LC[i]), 4'h4, 16'h0, 16'h0);
         chk("mode legality", {31'h0, LI[i]}, u_dec.got.illegal);
      end
      foreach (DP[i]) begin
         go(agm_pkg::agm_mode_t'(DM[i]), agm_pkg::CL_DSP, DP[i], 16'h0, DV[i]);
         chk("prefetch legality", {31'h0, DI[i]}, u_dec.got.illegal);
         if (!DI[i]) chk("prefetch space", {31'h0, DP[i][1]}, u_dec.got.y_space);
      end
      go(agm_pkg::MD_BRANCH, agm_pkg::CL_MCU, 4'h0, 16'h8001, 16'h0);
      chk("branch literal", 32'h8001, u_dec.got.opb);
      go(agm_pkg::MD_INTERRUPT_DISABLE_INSTRUCTION, agm_pkg::CL_MCU, 4'h0, 16'hffff, 16'h0);
      chk("disable count", 32'h3fff, u_dec.got.opb);
      for (int i = 0; i < 8; i++) begin
         rn = xs();
         p = 4'h4 + {2'h0, rn[1:0]};
         rn = xs();
         v = rn[15:0];
         rn = xs();
         implied_working_reg(p, v);
         go(agm_pkg::MD_LITOFF, agm_pkg::CL_MOVE, p, rn[15:0], 16'h0);
         chk("random offset", {16'h0, v + rn[15:0]}, u_dec.got.ea);
         ptr_is(p, v);
      end
      test_done();
   end
endmodule
